//--- inc/button_regs_defines.svh
`ifndef BUTTON_REGS_DEFINES_SVH
`define BUTTON_REGS_DEFINES_SVH

// register offsets
`define OFS_STATUS 8'h00
`define OFS_BTN0_LO 8'h02
`define OFS_BTN0_HI 8'h03
`define OFS_BTN1_LO 8'h04
`define OFS_BTN1_HI 8'h05
`define OFS_BTN2_LO 8'h06
`define OFS_BTN2_HI 8'h07
`define OFS_BTN3_LO 8'h08
`define OFS_BTN3_HI 8'h09
`define OFS_RST_CTL 8'h0a
`define OFS_CHAN_EN 8'h0c

// reset values
`define RST_CTL_RESET 8'h00
`define CHAN_EN_RESET 8'h1f
`define RESULT_RESET 8'h00

// field positions
`define BIT_FULL_RESET 4
`define BIT_CONFIG_HOLD 0
`define BIT_CHIP_READY 6
`define BIT_SATURATION 4
`define RESULT_LO_BITS 8

// timing
`define CLK_PERIOD_NS 10
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// bus address, value is arbitrary
`define I2C_DEV_ADDR 7'h2a

`endif

//--- inc/button_regs_pkg.sv
package button_regs_pkg;

  typedef enum logic [3:0] {
    i2c_idle,
    i2c_addr,
    i2c_addr_ack,
    i2c_addr_hold,
    i2c_wr,
    i2c_wr_ack,
    i2c_wr_hold,
    i2c_rd,
    i2c_rd_ack
  } i2c_state_t;

  typedef struct packed {
    i2c_state_t st;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic rw;
    logic ptr_set;
    logic ack_ok;
    logic [7:0] ptr;
    logic sda_out;
    logic sda_oe;
    logic cfg_hold;
    logic [7:0] chan_en;
    logic sat;
    logic soft_rst;
    logic run;
    logic [3:0] chan_on;
    logic [3:0] lp_on;
  } top_state_t;

endpackage

//--- hdl/ready_timer.sv
`timescale 1ns/1ps
`include "button_regs_defines.svh"

module ready_timer #(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  output logic ready_q
);

  localparam int CW = $clog2(INIT_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ready;
  } timer_state_t;

  timer_state_t q;
  timer_state_t d;

  always_comb begin
    d = q;
    if (start) begin
      // not ready until initialization finishes
      d.cnt = CW'(INIT_CYCLES);
      d.ready = 1'b0;
    end else if (!q.ready) begin
      if (q.cnt <= CW'(1)) begin
        d.cnt = '0;
        d.ready = 1'b1;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{cnt: '0, ready: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign ready_q = q.ready;

endmodule // ready_timer

//--- hdl/sample_capture.sv
`timescale 1ns/1ps

module sample_capture #(
  parameter int CHANNELS = 4,
  parameter int WIDTH = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic take,
  input wire logic [CHANNELS*WIDTH-1:0] sample,
  output logic [CHANNELS*WIDTH-1:0] value_q,
  output logic sat_q
);

  typedef struct packed {
    logic [CHANNELS*WIDTH-1:0] value;
    logic sat;
  } cap_state_t;

  cap_state_t q;
  cap_state_t d;

  function automatic logic at_limit(input logic [WIDTH-1:0] v);
    return (v == {1'b0, {(WIDTH-1){1'b1}}}) ||
           (v == {1'b1, {(WIDTH-1){1'b0}}});
  endfunction

  always_comb begin
    d = q;
    d.sat = 1'b0;
    if (clear) begin
      d.value = '0;
    end else if (take) begin
      // all channels latch in one edge, so byte pairs stay coherent
      d.value = sample;
      for (int i = 0; i < CHANNELS; i++) begin
        if (at_limit(sample[i*WIDTH +: WIDTH])) begin
          d.sat = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value_q = q.value;
  assign sat_q = q.sat;

endmodule // sample_capture

//--- hdl/button_regs_top.sv
// How it works
// - each result is 12-bit signed: low byte, then four bits, top nibble zero
// - channel results pair at consecutive offsets, low byte first, reset zero
// - writing one to full-reset bit returns every register to default
// - after full reset, no conversion until the chip reports ready
// - config-hold bit set stops conversion but keeps all settings
// - enable bits 3..0 switch sensing channels 3..0 on or off
// - bits 7..4 enable low power per channel, only with normal enable
// - enable register resets to 1f: all channels on, channel 0 low power
// - reset control resets to 00, reserved bits read zero
// - saturation flag sets at result +7ff or -800, status read clears
// - status bit 6 reads zero until chip ready, then one
`timescale 1ns/1ps
`include "button_regs_defines.svh"

module button_regs_top #(
  parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR,
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic result_valid,
  input wire logic [47:0] result_data,
  output logic conv_run,
  output logic [3:0] chan_active,
  output logic [3:0] lowpower_on,
  output logic chip_ready
);

  localparam int WIDTH = 12;
  localparam int CHANNELS = 4;

  button_regs_pkg::top_state_t q;
  button_regs_pkg::top_state_t d;

  logic [CHANNELS*WIDTH-1:0] values;
  logic sat_pulse;
  logic ready;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic load_rd;
  logic wr_en;
  logic clr_sat;

  function automatic logic [7:0] reg_read(
    input logic [7:0] ofs,
    input logic [CHANNELS*WIDTH-1:0] vals,
    input logic rdy,
    input logic sat,
    input logic cfg,
    input logic [7:0] en
  );
    logic [7:0] r;
    logic [WIDTH-1:0] v;
    logic [7:0] k;
    r = 8'h00;
    v = '0;
    k = 8'h00;
    if (ofs >= `OFS_BTN0_LO && ofs <= `OFS_BTN3_HI) begin
      k = (ofs - `OFS_BTN0_LO) >> 1;
      v = vals[k[1:0]*WIDTH +: WIDTH];
      if (ofs[0]) begin
        // reserved upper nibble reads zero
        r = {4'h0, v[WIDTH-1:`RESULT_LO_BITS]};
      end else begin
        r = v[`RESULT_LO_BITS-1:0];
      end
    end else begin
      case (ofs)
        `OFS_STATUS: begin
          r[`BIT_CHIP_READY] = rdy;
          r[`BIT_SATURATION] = sat;
        end
        `OFS_RST_CTL: begin
          // full reset self-clears, so only the hold bit reads back
          r[`BIT_CONFIG_HOLD] = cfg;
        end
        `OFS_CHAN_EN: begin
          r = en;
        end
        default: begin
          r = 8'h00;
        end
      endcase
    end
    return r;
  endfunction

  sample_capture #(
    .CHANNELS(CHANNELS),
    .WIDTH(WIDTH)
  ) u_capture (
    .clock(clock),
    .rst_b(rst_b),
    .clear(q.soft_rst),
    .take(result_valid && q.run),
    .sample(result_data),
    .value_q(values),
    .sat_q(sat_pulse)
  );

  ready_timer #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_ready (
    .clock(clock),
    .rst_b(rst_b),
    .start(q.soft_rst),
    .ready_q(ready)
  );

  // pins are taken as synchronous, one register suffices for edges
  assign scl_rise = !q.scl_q && scl_in;
  assign scl_fall = q.scl_q && !scl_in;
  assign bus_start = q.scl_q && scl_in && q.sda_q && !sda_in;
  assign bus_stop = q.scl_q && scl_in && !q.sda_q && sda_in;
  assign byte_in = {q.shift[6:0], sda_in};
  assign rd_byte = reg_read(q.ptr, values, ready, q.sat, q.cfg_hold,
                            q.chan_en);

  always_comb begin
    d = q;
    d.scl_q = scl_in;
    d.sda_q = sda_in;
    d.soft_rst = 1'b0;
    d.sda_out = 1'b0;
    load_rd = 1'b0;
    wr_en = 1'b0;
    clr_sat = 1'b0;

    case (q.st)
      button_regs_pkg::i2c_idle: begin
        d.sda_oe = 1'b0;
      end
      button_regs_pkg::i2c_addr: begin
        if (scl_rise) begin
          d.shift = byte_in;
          d.bit_cnt = q.bit_cnt + 3'd1;
          if (q.bit_cnt == 3'd7) begin
            if (byte_in[7:1] == DEV_ADDR) begin
              d.rw = byte_in[0];
              d.ptr_set = byte_in[0] ? q.ptr_set : 1'b0;
              d.st = button_regs_pkg::i2c_addr_ack;
            end else begin
              d.st = button_regs_pkg::i2c_idle;
            end
          end
        end
      end
      button_regs_pkg::i2c_addr_ack: begin
        if (scl_fall) begin
          d.sda_oe = 1'b1;
          d.st = button_regs_pkg::i2c_addr_hold;
        end
      end
      button_regs_pkg::i2c_addr_hold: begin
        if (scl_fall) begin
          if (q.rw) begin
            load_rd = 1'b1;
          end else begin
            d.sda_oe = 1'b0;
            d.bit_cnt = 3'd0;
            d.st = button_regs_pkg::i2c_wr;
          end
        end
      end
      button_regs_pkg::i2c_wr: begin
        if (scl_rise) begin
          d.shift = byte_in;
          d.bit_cnt = q.bit_cnt + 3'd1;
          if (q.bit_cnt == 3'd7) begin
            d.st = button_regs_pkg::i2c_wr_ack;
            if (!q.ptr_set) begin
              d.ptr = byte_in;
              d.ptr_set = 1'b1;
            end else begin
              wr_en = 1'b1;
              d.ptr = q.ptr + 8'h01;
            end
          end
        end
      end
      button_regs_pkg::i2c_wr_ack: begin
        if (scl_fall) begin
          d.sda_oe = 1'b1;
          d.st = button_regs_pkg::i2c_wr_hold;
        end
      end
      button_regs_pkg::i2c_wr_hold: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.bit_cnt = 3'd0;
          d.st = button_regs_pkg::i2c_wr;
        end
      end
      button_regs_pkg::i2c_rd: begin
        if (scl_fall) begin
          if (q.bit_cnt == 3'd7) begin
            d.sda_oe = 1'b0;
            d.st = button_regs_pkg::i2c_rd_ack;
          end else begin
            d.shift = {q.shift[6:0], 1'b0};
            d.bit_cnt = q.bit_cnt + 3'd1;
            d.sda_oe = !q.shift[6];
          end
        end
      end
      button_regs_pkg::i2c_rd_ack: begin
        if (scl_rise) begin
          d.ack_ok = !sda_in;
        end else if (scl_fall) begin
          if (q.ack_ok) begin
            load_rd = 1'b1;
          end else begin
            d.st = button_regs_pkg::i2c_idle;
          end
        end
      end
      default: begin
        d.st = button_regs_pkg::i2c_idle;
        d.sda_oe = 1'b0;
      end
    endcase

    // the byte is frozen at load, so a read-clear cannot tear it
    if (load_rd) begin
      d.shift = rd_byte;
      d.bit_cnt = 3'd0;
      d.ptr = q.ptr + 8'h01;
      d.sda_oe = !rd_byte[7];
      d.st = button_regs_pkg::i2c_rd;
      clr_sat = (q.ptr == `OFS_STATUS);
    end

    if (bus_start) begin
      d.st = button_regs_pkg::i2c_addr;
      d.bit_cnt = 3'd0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st = button_regs_pkg::i2c_idle;
      d.sda_oe = 1'b0;
    end

    // writes while initializing are dropped; host waits for ready
    if (wr_en && ready) begin
      if (q.ptr == `OFS_RST_CTL) begin
        d.cfg_hold = byte_in[`BIT_CONFIG_HOLD];
        d.soft_rst = byte_in[`BIT_FULL_RESET];
      end else if (q.ptr == `OFS_CHAN_EN) begin
        d.chan_en = byte_in;
      end
    end

    // set wins over the status-read clear
    if (clr_sat) begin
      d.sat = 1'b0;
    end
    if (sat_pulse) begin
      d.sat = 1'b1;
    end

    if (d.soft_rst) begin
      d.cfg_hold = 1'(`RST_CTL_RESET >> `BIT_CONFIG_HOLD);
      d.chan_en = `CHAN_EN_RESET;
      d.sat = 1'b0;
    end

    d.run = ready && !q.cfg_hold && !q.soft_rst;
    d.chan_on = q.chan_en[3:0];
    d.lp_on = q.chan_en[7:4] & q.chan_en[3:0];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= button_regs_pkg::i2c_idle;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
      q.chan_en <= `CHAN_EN_RESET;
      q.cfg_hold <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign sda_out = q.sda_out;
  assign sda_oe = q.sda_oe;
  assign conv_run = q.run;
  assign chan_active = q.chan_on;
  assign lowpower_on = q.lp_on;
  assign chip_ready = ready;

endmodule // button_regs_top

//--- testbench/button_regs_properties.sv
`timescale 1ns/1ps

module button_regs_checker #(
  parameter int INIT_CYCLES = 100
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic result_valid,
  input wire logic [47:0] result_data,
  input wire logic conv_run,
  input wire logic [3:0] chan_active,
  input wire logic [3:0] lowpower_on,
  input wire logic chip_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // cycles spent not ready, held against the init length
  int low_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= chip_ready ? 0 : low_cnt + 1;
    end
  end

  sequence s_init_low;
    !chip_ready [*3];
  endsequence
  sequence s_defaults;
    chan_active == 4'hf && lowpower_on == 4'h1;
  endsequence

  property p_lp_gated;
    (lowpower_on & ~chan_active) == 4'h0;
  endproperty
  property p_run_ready;
    conv_run |-> chip_ready;
  endproperty
  property p_init_span;
    $fell(chip_ready) |-> s_init_low ##[1:1000] chip_ready;
  endproperty
  property p_init_len;
    $rose(chip_ready) |-> low_cnt == INIT_CYCLES;
  endproperty
  property p_soft_defaults;
    $fell(chip_ready) |-> ##[0:3] s_defaults;
  endproperty
  property p_run_resumes;
    $rose(chip_ready) |-> ##[0:2] conv_run;
  endproperty
  property p_por_defaults;
    $rose(rst_b) |=> s_defaults ##0 conv_run;
  endproperty
  property p_ready_defaults;
    $rose(chip_ready) |-> s_defaults;
  endproperty
  // bus answers only move while scl is low, never under a high clock
  property p_oe_on_low;
    $changed(sda_oe) |-> !$past(scl_in);
  endproperty

  a_lp_gated: assert property (p_lp_gated)
    else $error("low power on disabled channel");
  a_run_ready: assert property (p_run_ready)
    else $error("conversion while not ready");
  a_init_span: assert property (p_init_span)
    else $error("init span wrong");
  a_init_len: assert property (p_init_len)
    else $error("init length wrong");
  a_soft_defaults: assert property (p_soft_defaults)
    else $error("no defaults after soft reset");
  a_run_resumes: assert property (p_run_resumes)
    else $error("conversion not resumed");
  a_por_defaults: assert property (p_por_defaults)
    else $error("wrong state after reset");
  a_ready_defaults: assert property (p_ready_defaults)
    else $error("enables not default at ready");
  a_oe_on_low: assert property (p_oe_on_low)
    else $error("sda moved under high scl");
endmodule // button_regs_checker

bind button_regs_top button_regs_checker #(.INIT_CYCLES(INIT_CYCLES)) chk (
  .clock(clock), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .result_valid(result_valid),
  .result_data(result_data), .conv_run(conv_run),
  .chan_active(chan_active), .lowpower_on(lowpower_on),
  .chip_ready(chip_ready));

//--- testbench/i2c_host_model.sv
`timescale 1ns/1ps

module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  logic [7:0] rx;
  logic n;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // two clocks a phase: slow enough for the synchronous scl sampling
  task automatic ph(input logic c, input logic d);
    @(posedge clock);
    scl <= c;
    sda <= d;
    @(posedge clock);
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, sda);
    ph(1'b0, b);
    ph(1'b1, b);
    #1 r = sda_line;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ai,
      output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r[i]);
    end
    bit_io(ai, ao);
  endtask
  task automatic start;
    ph(1'b0, sda);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic stop;
    ph(1'b0, sda);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] o,
      input logic [7:0] d, output logic ack);
    start();
    xfer({a, 1'b0}, 1'b1, rx, n);
    ack = !n;
    xfer(o, 1'b1, rx, n);
    xfer(d, 1'b1, rx, n);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] o, output logic [7:0] d);
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, n);
    xfer(o, 1'b1, rx, n);
    start();
    xfer({ADDR, 1'b1}, 1'b1, rx, n);
    xfer(8'hff, 1'b1, d, n);
    stop();
  endtask
endmodule // i2c_host_model

//--- testbench/button_data_reset_enable_regs_test.sv
`timescale 1ns/1ps

module button_data_reset_enable_regs_test;
  localparam logic [6:0] ADDR = 7'h2a; // arbitrary
  logic clock, rst_b, scl, host_sda, sda_out, sda_oe, result_valid;
  logic conv_run, chip_ready, ack;
  logic [3:0] chan_active, lowpower_on;
  logic [47:0] result_data;
  logic [7:0] rd;
  logic [11:0] val [4];
  logic [15:0] rows [5];
  int num_errors, n_tests;
  wire logic sda_line = host_sda & ~sda_oe;

  button_regs_top #(.DEV_ADDR(ADDR), .INIT_CYCLES(4)) uut (
    .clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .result_valid(result_valid),
    .result_data(result_data), .conv_run(conv_run),
    .chan_active(chan_active), .lowpower_on(lowpower_on),
    .chip_ready(chip_ready));
  i2c_host_model #(.ADDR(ADDR)) host (.clock(clock),
    .sda_line(sda_line), .scl(scl), .sda(host_sda));

  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic rchk(input logic [7:0] o, input logic [7:0] e);
    host.read_reg(o, rd);
    chk($sformatf("reg %h", o), e, rd);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    host.write_reg(ADDR, o, d, ack);
  endtask
  task automatic pulse;
    @(posedge clock);
    result_valid <= 1'b1;
    result_data <= {val[3], val[2], val[1], val[0]};
    @(posedge clock);
    result_valid <= 1'b0;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst_b = 1'b0;
    result_valid = 1'b0;
    result_data = 48'h0;
    num_errors = 0;
    n_tests = 0;
    val = '{12'h7ff, 12'h800, 12'h5a3, 12'h0c4};
    // rows: enable byte, expected chan_active, expected lowpower_on
    rows = '{16'h5555, 16'hf000, 16'ha332, 16'h0ff0, 16'h1ff1};
    repeat (4) @(posedge clock);
    chk("ready in reset", 8'h1, {7'h0, chip_ready});
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk("chan_active", 8'h0f, {4'h0, chan_active});
    chk("lowpower_on", 8'h01, {4'h0, lowpower_on});
    rchk(8'h0c, 8'h1f);
    rchk(8'h0a, 8'h00);
    rchk(8'h00, 8'h40);
    for (int k = 2; k < 10; k++) rchk(8'(k), 8'h00);
    wr(8'h0a, 8'hef);
    @(posedge clock);
    chk("conv_run hold", 8'h0, {7'h0, conv_run});
    rchk(8'h0a, 8'h01);
    pulse();
    rchk(8'h02, 8'h00);
    rchk(8'h00, 8'h40);
    foreach (rows[i]) begin
      wr(8'h0c, rows[i][15:8]);
      @(posedge clock);
      chk("chan_active", {4'h0, rows[i][7:4]}, {4'h0, chan_active});
      chk("lowpower_on", {4'h0, rows[i][3:0]}, {4'h0, lowpower_on});
      rchk(8'h0c, rows[i][15:8]);
    end
    wr(8'h0a, 8'h00);
    @(posedge clock);
    chk("conv_run", 8'h1, {7'h0, conv_run});
    pulse();
    rchk(8'h00, 8'h50);
    rchk(8'h00, 8'h40);
    for (int k = 0; k < 4; k++) begin
      rchk(8'(2 + 2 * k), val[k][7:0]);
      rchk(8'(3 + 2 * k), {4'h0, val[k][11:8]});
    end
    wr(8'h04, 8'h33);
    rchk(8'h04, val[1][7:0]);
    rchk(8'h0b, 8'h00);
    host.write_reg(ADDR ^ 7'h01, 8'h0c, 8'h00, ack);
    chk("ack other addr", 8'h0, {7'h0, ack});
    rchk(8'h0c, 8'h1f);
    wr(8'h0c, 8'h00);
    wr(8'h0a, 8'h10);
    for (int i = 0; i < 200 && chip_ready !== 1'b1; i++) @(posedge clock);
    chk("chip_ready", 8'h1, {7'h0, chip_ready});
    if (chip_ready !== 1'b1) give_verdict();
    rchk(8'h0c, 8'h1f);
    rchk(8'h0a, 8'h00);
    rchk(8'h00, 8'h40);
    rchk(8'h02, 8'h00);
    chk("sda_out", 8'h0, {7'h0, sda_out});
    give_verdict();
  end
endmodule // button_data_reset_enable_regs_test
